/* hw/forward_prohibit_input_select.sv */
/*
  Forward drive prohibit input selection with an APB register slave.
  Assumes asynchronous terminal inputs, one 250 MHz clock pclk and an
  asynchronous active low reset presetn.
*/
// How it works
// RULE1 - Top hex digit of the selection setting chooses prohibit source and polarity.
// RULE2 - Codes 0 to 6 pick terminals 13,7..12; drive allowed while input closed.
// RULE3 - Code 7 keeps forward drive prohibited regardless of terminal levels.
// RULE4 - Code 8 keeps forward drive allowed, ignoring all terminals.
// RULE5 - Codes 9 to F pick terminals 13,7..12; drive allowed while input open.
// RULE6 - A changed selection takes effect only at the next restart.
`timescale 1ns/10ps
`include "fwd_prohibit_defines.svh"

module forward_prohibit_input_select
  import fwd_prohibit_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  io_connector_terminals,
  input  wire logic        restart,
  output logic             forward_drive_prohibit
);

  // Bit 0 is terminal 13, bits 1..6 are terminals 7..12.
  logic [6:0]  term_s1_q;
  logic [6:0]  term_s2_q;
  logic [6:0]  term_s3_q;
  logic [6:0]  term_q;
  logic [1:0]  restart_sync_q;
  logic        restart_s3_q;
  logic        restart_lvl_q;
  logic [15:0] input_signal_selection_one_q;
  logic [15:0] active_sel_q;
  logic        sw_restart_q;
  logic        prohibit_d;
  fwd_select_t sel;
  logic [3:0]  digit;
  logic        access;
  logic        restart_evt;
  logic        term_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_s1_q <= 7'h00;
      term_s2_q <= 7'h00;
      term_s3_q <= 7'h00;
    end else begin
      term_s1_q <= io_connector_terminals;
      term_s2_q <= term_s1_q;
      term_s3_q <= term_s2_q;
    end
  end

  // A terminal change counts only once two later stages agree, masking glitches.
  genvar g;
  generate
    for (g = 0; g < `NUM_TERMINALS; g = g + 1) begin : g_term
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          term_q[g] <= 1'b0;
        end else if (term_s2_q[g] == term_s3_q[g]) begin
          term_q[g] <= term_s2_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_sync_q <= 2'b00;
      restart_s3_q   <= 1'b0;
      restart_lvl_q  <= 1'b0;
    end else begin
      restart_sync_q <= {restart_sync_q[0], restart};
      restart_s3_q   <= restart_sync_q[1];
      if (restart_sync_q[1] == restart_s3_q) begin
        restart_lvl_q <= restart_s3_q;
      end
    end
  end

  assign restart_evt = (restart_sync_q[1] == restart_s3_q) && restart_s3_q
                       && !restart_lvl_q;
  assign access = psel && penable;

  // The bus answers in the access cycle itself, so no wait states are inserted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_signal_selection_one_q <= `SEL_ONE_RESET;
    end else if (access && pwrite && paddr == `SEL_ONE_OFFSET) begin
      if (pstrb[0]) begin
        input_signal_selection_one_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        input_signal_selection_one_q[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_restart_q <= 1'b0;
    end else begin
      sw_restart_q <= access && pwrite && paddr == `RESTART_OFFSET && pstrb[0]
                      && pwdata[`RESTART_GO_BIT];
    end
  end

  // Only a restart moves the new setting into force. [RULE6]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_sel_q <= `SEL_ONE_RESET;
    end else if (restart_evt || sw_restart_q) begin
      active_sel_q <= input_signal_selection_one_q; // [RULE6]
    end
  end

  assign digit = active_sel_q[`FWD_DIGIT_MSB:`FWD_DIGIT_LSB]; // [RULE1]

  always_comb begin
    sel.terminal = 3'd0;
    sel.mode     = src_closed;
    if (digit <= `CODE_LAST_CLOSED) begin
      sel.mode     = src_closed; // [RULE2]
      sel.terminal = digit[2:0];
    end else if (digit == `CODE_ALWAYS_PROHIB) begin
      sel.mode = src_always_prohibit; // [RULE3]
    end else if (digit == `CODE_ALWAYS_ALLOW) begin
      sel.mode = src_always_allow; // [RULE4]
    end else begin
      sel.mode     = src_open; // [RULE5]
      sel.terminal = 3'(digit - `CODE_FIRST_OPEN);
    end
  end

  assign term_level = term_q[sel.terminal];

  always_comb begin
    case (sel.mode)
      src_closed:          prohibit_d = !term_level; // [RULE2]
      src_open:            prohibit_d = term_level; // [RULE5]
      src_always_prohibit: prohibit_d = 1'b1; // [RULE3]
      src_always_allow:    prohibit_d = 1'b0; // [RULE4]
      default:             prohibit_d = 1'b1;
    endcase
  end

  // Reset leaves drive prohibited, the safe side; the first clock after reset loads prohibit_d, before inputs have passed the sync stages.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_drive_prohibit <= 1'b1;
    end else begin
      forward_drive_prohibit <= prohibit_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `SEL_ONE_OFFSET:    prdata <= {16'h0000, input_signal_selection_one_q};
          `ACTIVE_SEL_OFFSET: prdata <= {16'h0000, active_sel_q};
          `STATUS_OFFSET: begin
            prdata[`STATUS_PROHIBIT_BIT] <= forward_drive_prohibit;
            prdata[`STATUS_PENDING_BIT]  <= active_sel_q != input_signal_selection_one_q;
            prdata[8 +: 7]               <= term_q;
          end
          `RESTART_OFFSET:    prdata <= 32'h0000_0000;
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

/* hw/fwd_prohibit_defines.svh */
/*
  Register offsets, field positions, reset values and code points for the
  forward drive prohibit input selection block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FWD_PROHIBIT_DEFINES_SVH
`define FWD_PROHIBIT_DEFINES_SVH

`define SEL_ONE_OFFSET      12'h000
`define ACTIVE_SEL_OFFSET   12'h004
`define STATUS_OFFSET       12'h008
`define RESTART_OFFSET      12'h00C

`define SEL_ONE_RESET       16'h8881
`define FWD_DIGIT_MSB       15
`define FWD_DIGIT_LSB       12

`define CODE_LAST_CLOSED    4'h6
`define CODE_ALWAYS_PROHIB  4'h7
`define CODE_ALWAYS_ALLOW   4'h8
`define CODE_FIRST_OPEN     4'h9

`define NUM_TERMINALS       7
`define STATUS_PROHIBIT_BIT 0
`define STATUS_PENDING_BIT  1
`define RESTART_GO_BIT      0

`endif

/* hw/fwd_prohibit_pkg.sv */
/*
  Types shared by the forward drive prohibit input selection block.
  Assumes the defines header is available on the include path.
*/
package fwd_prohibit_pkg;
  typedef enum logic [1:0] {
    src_closed,
    src_open,
    src_always_prohibit,
    src_always_allow
  } src_mode_t;

  typedef struct packed {
    src_mode_t   mode;
    logic [2:0]  terminal;
  } fwd_select_t;
endpackage

/* sim/forward_prohibit_input_select_tb.sv */
/* Self-checking bench for the forward prohibit selector.
   Assumes the switch model and the checker bind are compiled first. */
`timescale 1ns/10ps
module forward_prohibit_input_select_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, restart = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, fdp;
  logic [6:0]  closed_req = 0, terms;
  int          failures = 0, checks = 0;
  always #2 pclk = ~pclk;
  limit_switch_model limit_switch_model_inst (.pclk(pclk), .closed_req(closed_req),
    .io_connector_terminals(terms));
  forward_prohibit_input_select forward_prohibit_input_select_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_connector_terminals(terms), .restart(restart), .forward_drive_prohibit(fdp));
  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  function logic exp_p(input logic [3:0] c, input logic [6:0] t);
    if (c == 4'h7) return 1'b1;
    if (c == 4'h8) return 1'b0;
    return (c < 4'h7) ? !t[c] : t[c - 4'h9];
  endfunction
  initial begin
    logic [3:0] c, prev;
    logic [6:0] oh;
    prev = 4'h8;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0, rd); chk("sel reset", 32'h0000_8881, rd);
    chk("allow after reset", 0, fdp);
    apb(0, 12'h010, 0, rd); chk("unmapped", 1, err);
    apb(0, 12'h004, 0, rd); chk("active reset", 32'h0000_8881, rd);
    apb(0, 12'h008, 0, rd); chk("status reset", 32'h0000_0000, rd);
    apb(1, 12'h000, 32'h0000_7881, rd);
    apb(0, 12'h008, 0, rd); chk("status pending", 32'h0000_0002, rd);
    apb(1, 12'h000, 32'h0000_8881, rd);
    apb(0, 12'h008, 0, rd); chk("status clear", 32'h0000_0000, rd);
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      oh = 7'h01 << ((c > 4'h8) ? c - 4'h9 : c);
      apb(1, 12'h000, {16'h0000, c, 12'h881}, rd);
      repeat (10) @(posedge pclk);
      chk("held", exp_p(prev, closed_req), fdp);
      if (c == 4'hf) begin
        restart <= 1;
        repeat (10) @(posedge pclk);
        restart <= 0;
      end else apb(1, 12'h00C, 1, rd);
      closed_req <= oh;
      repeat (10) @(posedge pclk);
      chk("sel closed", exp_p(c, oh), fdp);
      closed_req <= ~oh;
      repeat (10) @(posedge pclk);
      chk("sel open", exp_p(c, ~oh), fdp);
      prev = c;
    end
    wrap_up();
  end
endmodule

/* sim/fps_props.sv */
/* Port checker for the forward prohibit selector.
   Assumes it is bound onto forward_prohibit_input_select. */
`timescale 1ns/10ps
module fps_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        forward_drive_prohibit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error data");
  a_mapped_no_err: assert property (pready && paddr <= 12'h00C && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped error");
  a_status_tracks: assert property (pready && !pwrite && paddr == 12'h008 |->
    prdata[0] == $past(forward_drive_prohibit)) else $error("status bit");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  c_err: cover property (pready && pslverr);
  c_rise: cover property ($rose(forward_drive_prohibit));
  c_fall: cover property ($fell(forward_drive_prohibit));
endmodule
bind forward_prohibit_input_select fps_props fps_props_inst (.*);

/* sim/limit_switch_model.sv */
/* Limit switch bank on the terminal inputs.
   Assumes the bench requests contact states on the clock. */
`timescale 1ns/10ps
module limit_switch_model (
  input  wire logic       pclk,
  input  wire logic [6:0] closed_req,
  output logic      [6:0] io_connector_terminals
);
  // Contacts settle a cycle late, so the design never sees an instant change.
  always_ff @(posedge pclk) begin
    io_connector_terminals <= closed_req;
  end
endmodule
